// ---- core/ssp_engine.sv ----
// stack push/pop engine: selector, error code, pop-to-memory and far-call pushes
// assumes a memory port that answers each request with one i_mem_ack pulse
`timescale 1ns/1ps
`default_nettype none
module ssp_engine import ssp_pkg::*; #(
    parameter ssp_var_t VARIANT = VAR_PRIMARY
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_cmd_valid,
    input wire ssp_op_t i_cmd_op,
    input wire logic i_op32,
    input wire logic i_stk32,
    input wire logic [31:0] i_sp,
    input wire logic [15:0] i_sel,
    input wire logic [15:0] i_err_code,
    input wire logic [31:0] i_ip,
    input wire logic [31:0] i_ea,
    input wire logic [31:0] i_idx_disp,
    input wire logic i_sp_base32,
    input wire logic i_prot_mode,
    input wire logic i_ss_big,
    input wire logic i_hi_bytes_bad,
    input wire logic i_br_limit_viol,
    input wire logic i_br_rights_viol,
    input wire logic i_abort,
    input wire logic i_mem_ack,
    input wire logic [31:0] i_mem_rdata,
    output logic o_busy,
    output logic o_done,
    output logic o_fault,
    output ssp_fault_t o_fault_code,
    output logic [31:0] o_sp,
    output logic [31:0] o_pop_data,
    output logic o_mem_req,
    output logic o_mem_we,
    output logic [31:0] o_mem_addr,
    output logic [31:0] o_mem_wdata,
    output logic [3:0] o_mem_be
);
    // ==========================================
    // helpers
    function automatic logic [31:0] sp_step(input logic [31:0] sp, input logic [31:0] dlt,
                                           input logic stk32, input logic down);
        logic [31:0] r;
        r = down ? (sp - dlt) : (sp + dlt);
        sp_step = stk32 ? r : {sp[31:16], r[15:0]};
    endfunction : sp_step

    function automatic logic [31:0] op_size(input logic op32);
        op_size = op32 ? SZ32 : SZ16;
    endfunction : op_size

    // ==========================================
    // state
    ssp_state_t state_q, state_d;
    ssp_op_t op_q, op_d;
    logic op32_q, op32_d, stk32_q, stk32_d;
    logic second_q, second_d, wrap_q, wrap_d, big_q, big_d;
    logic [31:0] sp0_q, sp0_d, sp_q, sp_d, ip_q, ip_d, ea_q, ea_d, idx_q, idx_d;
    logic [31:0] pop_q, pop_d, addr_q, addr_d, wdata_q, wdata_d;
    logic [3:0] be_q, be_d;
    logic req_q, req_d, we_q, we_d, done_q, done_d, fault_q, fault_d;
    ssp_fault_t fcode_q, fcode_d;

    // ==========================================
    // decode
    wire is_alt = (VARIANT == VAR_ALT);
    wire is_legacy = (VARIANT == VAR_LEGACY);
    wire br_fault = i_br_limit_viol | i_br_rights_viol;
    wire hi_fault = is_alt & i_op32 & i_hi_bytes_bad;
    wire [3:0] sel_be = (is_alt & i_op32) ? BE_ALL : BE_LO;
    wire [3:0] pop_be = (is_alt & i_op32) ? BE_ALL : BE_LO;
    wire [31:0] in_size = op_size(i_op32);
    wire [31:0] q_size = op_size(op32_q);
    wire [31:0] err_size = i_stk32 ? SZ32 : SZ16;
    wire [3:0] err_be = (is_legacy | ~i_stk32) ? BE_LO : BE_ALL;
    wire [31:0] push_sp = sp_step(i_sp, in_size, i_stk32, 1'b1);
    wire [31:0] err_sp = sp_step(i_sp, err_size, i_stk32, 1'b1);
    wire [15:0] wrap_pt = i_op32 ? WRAP_OP32 : WRAP_OP16;
    wire wrap_hit = ~i_stk32 & i_sp_base32 & (i_sp[15:0] == wrap_pt);
    wire [31:0] pop_mask = op32_q ? i_mem_rdata : {HI_ZERO, i_mem_rdata[15:0]};
    wire [31:0] pop_sp = sp_step(sp_q, q_size, stk32_q, 1'b0);
    wire [31:0] call_sp = sp_step(sp_q, q_size, stk32_q, 1'b1);
    wire [31:0] wrap_ea = is_alt ? (WRAP_BIG_BASE + idx_q) : idx_q;
    wire wrap_flt = is_alt & wrap_q & ~big_q;

    // ==========================================
    // sequencing
    always_comb begin
        state_d = state_q;
        op_d = op_q;
        op32_d = op32_q;
        stk32_d = stk32_q;
        second_d = second_q;
        wrap_d = wrap_q;
        big_d = big_q;
        sp0_d = sp0_q;
        sp_d = sp_q;
        ip_d = ip_q;
        ea_d = ea_q;
        idx_d = idx_q;
        pop_d = pop_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        be_d = be_q;
        req_d = req_q;
        we_d = we_q;
        done_d = 1'b0;
        fault_d = 1'b0;
        fcode_d = fcode_q;
        case (state_q)
            ST_IDLE: begin
                if (i_cmd_valid) begin
                    op_d = i_cmd_op;
                    op32_d = i_op32;
                    stk32_d = i_stk32;
                    sp0_d = i_sp;
                    sp_d = i_sp;
                    ip_d = i_ip;
                    ea_d = i_ea;
                    idx_d = i_idx_disp;
                    wrap_d = wrap_hit;
                    big_d = i_prot_mode & i_ss_big;
                    second_d = 1'b0;
                    fcode_d = FLT_NONE;
                    case (i_cmd_op)
                        OP_PUSH_SEL: begin
                            if (hi_fault) begin
                                fault_d = 1'b1;
                                fcode_d = FLT_STACK;
                            end else begin
                                sp_d = push_sp;
                                addr_d = push_sp;
                                wdata_d = {HI_ZERO, i_sel};
                                be_d = sel_be;
                                we_d = 1'b1;
                                req_d = 1'b1;
                                state_d = ST_WR;
                            end
                        end
                        OP_POP_SEL: begin
                            if (hi_fault) begin
                                fault_d = 1'b1;
                                fcode_d = FLT_STACK;
                            end else begin
                                addr_d = i_sp;
                                be_d = pop_be;
                                we_d = 1'b0;
                                req_d = 1'b1;
                                state_d = ST_RD;
                            end
                        end
                        OP_PUSH_ERR: begin
                            sp_d = err_sp;
                            addr_d = err_sp;
                            wdata_d = {HI_ZERO, i_err_code};
                            be_d = err_be;
                            we_d = 1'b1;
                            req_d = 1'b1;
                            state_d = ST_WR;
                        end
                        OP_POP_MEM: begin
                            addr_d = i_sp;
                            be_d = i_op32 ? BE_ALL : BE_LO;
                            we_d = 1'b0;
                            req_d = 1'b1;
                            state_d = ST_RD;
                        end
                        OP_FAR_CALL: begin
                            if (br_fault) begin
                                fault_d = 1'b1;
                                fcode_d = FLT_BRANCH;
                            end else begin
                                sp_d = push_sp;
                                addr_d = push_sp;
                                wdata_d = {HI_ZERO, i_sel};
                                be_d = sel_be;
                                we_d = 1'b1;
                                req_d = 1'b1;
                                state_d = ST_WR;
                            end
                        end
                        default: begin
                            fault_d = 1'b1;
                            fcode_d = FLT_ABORT;
                        end
                    endcase
                end
            end
            ST_RD: begin
                if (i_abort) begin
                    sp_d = sp0_q;
                    req_d = 1'b0;
                    fault_d = 1'b1;
                    fcode_d = FLT_ABORT;
                    state_d = ST_IDLE;
                end else if (i_mem_ack) begin
                    req_d = 1'b0;
                    sp_d = pop_sp;
                    if (op_q == OP_POP_SEL) begin
                        pop_d = is_alt ? pop_mask : {HI_ZERO, i_mem_rdata[15:0]};
                        done_d = 1'b1;
                        state_d = ST_IDLE;
                    end else if (wrap_flt) begin
                        sp_d = sp0_q;
                        fault_d = 1'b1;
                        fcode_d = FLT_STACK;
                        state_d = ST_IDLE;
                    end else begin
                        pop_d = pop_mask;
                        addr_d = wrap_q ? wrap_ea : ea_q;
                        wdata_d = pop_mask;
                        we_d = 1'b1;
                        req_d = 1'b1;
                        state_d = ST_WR;
                    end
                end
            end
            ST_WR: begin
                if (i_abort) begin
                    sp_d = sp0_q;
                    req_d = 1'b0;
                    we_d = 1'b0;
                    fault_d = 1'b1;
                    fcode_d = FLT_ABORT;
                    state_d = ST_IDLE;
                end else if (i_mem_ack) begin
                    if ((op_q == OP_FAR_CALL) && !second_q) begin
                        second_d = 1'b1;
                        sp_d = call_sp;
                        addr_d = call_sp;
                        wdata_d = op32_q ? ip_q : {HI_ZERO, ip_q[15:0]};
                        be_d = op32_q ? BE_ALL : BE_LO;
                    end else begin
                        req_d = 1'b0;
                        we_d = 1'b0;
                        done_d = 1'b1;
                        state_d = ST_IDLE;
                    end
                end
            end
            default: begin
                req_d = 1'b0;
                we_d = 1'b0;
                state_d = ST_IDLE;
            end
        endcase
    end

    // ==========================================
    // registers
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= ST_IDLE;
            op_q <= OP_PUSH_SEL;
            op32_q <= 1'b0;
            stk32_q <= 1'b0;
            second_q <= 1'b0;
            wrap_q <= 1'b0;
            big_q <= 1'b0;
            sp0_q <= WORD_ZERO;
            sp_q <= WORD_ZERO;
            ip_q <= WORD_ZERO;
            ea_q <= WORD_ZERO;
            idx_q <= WORD_ZERO;
            pop_q <= WORD_ZERO;
            addr_q <= WORD_ZERO;
            wdata_q <= WORD_ZERO;
            be_q <= BE_NONE;
            req_q <= 1'b0;
            we_q <= 1'b0;
            done_q <= 1'b0;
            fault_q <= 1'b0;
            fcode_q <= FLT_NONE;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            op32_q <= op32_d;
            stk32_q <= stk32_d;
            second_q <= second_d;
            wrap_q <= wrap_d;
            big_q <= big_d;
            sp0_q <= sp0_d;
            sp_q <= sp_d;
            ip_q <= ip_d;
            ea_q <= ea_d;
            idx_q <= idx_d;
            pop_q <= pop_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            be_q <= be_d;
            req_q <= req_d;
            we_q <= we_d;
            done_q <= done_d;
            fault_q <= fault_d;
            fcode_q <= fcode_d;
        end
    end

    logic busy_q;
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (state_d != ST_IDLE);
        end
    end

    // ==========================================
    // outputs
    assign o_busy = busy_q;
    assign o_done = done_q;
    assign o_fault = fault_q;
    assign o_fault_code = fcode_q;
    assign o_sp = sp_q;
    assign o_pop_data = pop_q;
    assign o_mem_req = req_q;
    assign o_mem_we = we_q;
    assign o_mem_addr = addr_q;
    assign o_mem_wdata = wdata_q;
    assign o_mem_be = be_q;
endmodule : ssp_engine
`default_nettype wire

// ---- pkg/ssp_pkg.sv ----
// constants and types of the stack push/pop engine
// assumes one core clock and an execution pipeline issuing one command at a time
package ssp_pkg;
    typedef enum logic [2:0] {
        OP_PUSH_SEL = 3'b000,
        OP_POP_SEL = 3'b001,
        OP_PUSH_ERR = 3'b010,
        OP_POP_MEM = 3'b011,
        OP_FAR_CALL = 3'b100
    } ssp_op_t;

    typedef enum logic [1:0] {
        VAR_PRIMARY = 2'b00,
        VAR_ALT = 2'b01,
        VAR_LEGACY = 2'b10
    } ssp_var_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RD = 2'b01,
        ST_WR = 2'b10
    } ssp_state_t;

    typedef enum logic [1:0] {
        FLT_NONE = 2'b00,
        FLT_STACK = 2'b01,
        FLT_BRANCH = 2'b10,
        FLT_ABORT = 2'b11
    } ssp_fault_t;

    localparam logic [31:0] SZ16 = 32'h0000_0002;
    localparam logic [31:0] SZ32 = 32'h0000_0004;
    localparam logic [3:0] BE_LO = 4'h3;
    localparam logic [3:0] BE_ALL = 4'hF;
    localparam logic [3:0] BE_NONE = 4'h0;
    localparam logic [15:0] WRAP_OP32 = 16'hFFFC;
    localparam logic [15:0] WRAP_OP16 = 16'hFFFE;
    localparam logic [31:0] WRAP_BIG_BASE = 32'h0001_0000;
    localparam logic [15:0] HI_ZERO = 16'h0000;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
endpackage : ssp_pkg

// ---- tb/ssp_engine_checker.sv ----
// concurrent checks on the stack push/pop engine ports
// assumes it is bound to ssp_engine, one clock domain
`timescale 1ns/1ps
`default_nettype none
module ssp_engine_checker import ssp_pkg::*; (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_cmd_valid,
    input wire ssp_op_t i_cmd_op,
    input wire logic i_op32,
    input wire logic i_stk32,
    input wire logic [31:0] i_sp,
    input wire logic [15:0] i_sel,
    input wire logic [31:0] i_idx_disp,
    input wire logic i_sp_base32,
    input wire logic i_br_limit_viol,
    input wire logic i_br_rights_viol,
    input wire logic i_abort,
    input wire logic i_mem_ack,
    input wire logic o_busy,
    input wire logic o_done,
    input wire logic o_fault,
    input wire ssp_fault_t o_fault_code,
    input wire logic [31:0] o_sp,
    input wire logic o_mem_req,
    input wire logic o_mem_we,
    input wire logic [31:0] o_mem_addr,
    input wire logic [31:0] o_mem_wdata,
    input wire logic [3:0] o_mem_be
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    // ========
    // command capture
    wire logic take = i_cmd_valid && !o_busy;
    wire logic [15:0] wrap_pt = i_op32 ? WRAP_OP32 : WRAP_OP16;
    wire logic [31:0] size = i_op32 ? SZ32 : SZ16;
    ssp_op_t op_q;
    logic wrap_q;
    logic [31:0] sp_q, idx_q, sz_q;
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            op_q <= OP_PUSH_SEL;
            wrap_q <= 1'b0;
            sp_q <= 32'h0;
            idx_q <= 32'h0;
            sz_q <= 32'h0;
        end else if (take) begin
            op_q <= i_cmd_op;
            wrap_q <= i_cmd_op == OP_POP_MEM && !i_stk32 && i_sp_base32 && i_sp[15:0] == wrap_pt;
            sp_q <= i_sp;
            idx_q <= i_idx_disp;
            sz_q <= size;
        end
    end
    sequence s_take(ssp_op_t op);
        take && i_cmd_op == op;
    endsequence
    sequence s_rd_ack;
        o_mem_req && !o_mem_we && i_mem_ack;
    endsequence
    // ========
    // assertions
    AST_PUSH_SEL: assert property (s_take(OP_PUSH_SEL) ##0 i_stk32 |=> o_mem_req && o_mem_we && o_mem_be == BE_LO
        && o_mem_wdata[15:0] == $past(i_sel) && o_sp == $past(i_sp) - $past(size)) else $error("selector push wrong");
    AST_PUSH_DONE: assert property (o_mem_req && i_mem_ack && op_q == OP_PUSH_SEL |=> o_done && !o_busy)
        else $error("selector push not done after ack");
    AST_REQ_HOLD: assert property (o_mem_req && !i_mem_ack && !i_abort |=> o_mem_req && $stable(o_mem_addr)
        && $stable(o_mem_be) && $stable(o_mem_wdata)) else $error("memory request changed before ack");
    AST_POP_SEL: assert property (s_take(OP_POP_SEL) |=> o_mem_req && !o_mem_we && o_mem_be == BE_LO
        && o_mem_addr == $past(i_sp)) else $error("selector pop read wrong");
    AST_POP_SP: assert property (o_done && op_q == OP_POP_SEL |-> o_sp[15:0] == sp_q[15:0] + sz_q[15:0])
        else $error("selector pop pointer wrong");
    AST_ERR: assert property (s_take(OP_PUSH_ERR) ##0 i_stk32 |=> o_mem_be == BE_ALL
        && o_mem_wdata[31:16] == HI_ZERO && o_sp == $past(i_sp) - SZ32) else $error("error code push wrong");
    AST_WRAP: assert property (s_rd_ack ##0 wrap_q |=> o_mem_req && o_mem_we && o_mem_addr == idx_q)
        else $error("wrapped pop destination wrong");
    AST_BRANCH: assert property (s_take(OP_FAR_CALL) ##0 (i_br_limit_viol || i_br_rights_viol)
        |=> o_fault && o_fault_code == FLT_BRANCH && !o_mem_req) else $error("branch fault not immediate");
    AST_ABORT: assert property (o_busy && i_abort |=> o_fault && o_fault_code == FLT_ABORT
        && !o_mem_req && o_sp == sp_q) else $error("abort did not restore pointer");
endmodule : ssp_engine_checker
bind ssp_engine ssp_engine_checker u_chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid),
    .i_cmd_op(i_cmd_op), .i_op32(i_op32), .i_stk32(i_stk32), .i_sp(i_sp), .i_sel(i_sel), .i_idx_disp(i_idx_disp),
    .i_sp_base32(i_sp_base32), .i_br_limit_viol(i_br_limit_viol), .i_br_rights_viol(i_br_rights_viol),
    .i_abort(i_abort), .i_mem_ack(i_mem_ack), .o_busy(o_busy), .o_done(o_done), .o_fault(o_fault),
    .o_fault_code(o_fault_code), .o_sp(o_sp), .o_mem_req(o_mem_req), .o_mem_we(o_mem_we),
    .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_mem_be(o_mem_be));
`default_nettype wire

// ---- tb/ssp_engine_tb.sv ----
// self-checking bench for the stack push/pop engine
// assumes the primary variant and the behavioural stack memory
`timescale 1ns/1ps
`default_nettype none
module ssp_engine_tb import ssp_pkg::*;;
    logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0, op32 = 1'b0, stk32 = 1'b1, base32 = 1'b0;
    logic lim = 1'b0, rts = 1'b0, abt = 1'b0;
    ssp_op_t op = OP_PUSH_SEL;
    logic [31:0] sp = 32'h0, ip = 32'h0, idx = 32'h0;
    logic [15:0] sel = 16'h0, err = 16'h0;
    logic [3:0] dly = 4'h0;
    wire logic busy, done, flt, req, we, ack;
    wire ssp_fault_t fc;
    wire logic [31:0] osp, addr, wdat, rdat;
    wire logic [3:0] be;
    int bad_count = 0, samples_checked = 0, wr0;
    always #4 clk = ~clk;
    ssp_engine #(.VARIANT(VAR_PRIMARY)) u_dut (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_cmd_valid(vld), .i_cmd_op(op), .i_op32(op32), .i_stk32(stk32),
        .i_sp(sp), .i_sel(sel), .i_err_code(err), .i_ip(ip), .i_ea(32'h0000_0500), .i_idx_disp(idx),
        .i_sp_base32(base32), .i_prot_mode(1'b0), .i_ss_big(1'b0), .i_hi_bytes_bad(1'b0), .i_br_limit_viol(lim),
        .i_br_rights_viol(rts), .i_abort(abt), .i_mem_ack(ack), .i_mem_rdata(rdat), .o_busy(busy), .o_done(done),
        .o_fault(flt), .o_fault_code(fc), .o_sp(osp), .o_pop_data(), .o_mem_req(req), .o_mem_we(we),
        .o_mem_addr(addr), .o_mem_wdata(wdat), .o_mem_be(be));
    ssp_mem_model u_mem (.i_ref_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_we(we), .i_addr(addr),
        .i_wdata(wdat), .i_be(be), .i_dly(dly), .o_ack(ack), .o_rdata(rdat));
    // ========
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic run(input ssp_op_t o, input int ab);
        int n;
        n = 0;
        op = o;
        vld = 1'b1;
        @(posedge clk) #1;
        vld = 1'b0;
        while (!(done || flt) && n < 60) begin
            abt = (n == ab);
            @(posedge clk) #1;
            n++;
        end
        abt = 1'b0;
        if (n >= 60) chk("completion", 32'h0, 32'h1);
    endtask : run
    task conclude;
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    // ========
    // scenarios
    task automatic t_push_sel;
        for (int i = 0; i < 2; i++) begin
            op32 = i[0];
            sp = 32'h0000_0100;
            sel = 16'h1234;
            dly = i[0] ? 4'h3 : 4'h0;
            u_mem.mem[sp - (i[0] ? 32'h4 : 32'h2)] = 32'hA5A5_A5A5;
            run(OP_PUSH_SEL, -1);
            chk("push sp", sp - (i[0] ? 32'h4 : 32'h2), osp);
            chk("push slot", 32'hA5A5_1234, u_mem.mem[sp - (i[0] ? 32'h4 : 32'h2)]);
        end
    endtask : t_push_sel
    task automatic t_pop_sel;
        for (int i = 0; i < 2; i++) begin
            op32 = i[0];
            sp = 32'h0000_0200;
            u_mem.mem[sp] = 32'hBEEF_5678;
            run(OP_POP_SEL, -1);
            chk("pop data", 32'h0000_5678, u_dut.o_pop_data);
            chk("pop sp", sp + (i[0] ? 32'h4 : 32'h2), osp);
        end
    endtask : t_pop_sel
    task automatic t_push_err;
        sp = 32'h0000_0300;
        err = 16'h00C3;
        u_mem.mem[32'h0000_02FC] = 32'hA5A5_A5A5;
        run(OP_PUSH_ERR, -1);
        chk("error code slot", 32'h0000_00C3, u_mem.mem[32'h0000_02FC]);
        chk("error code sp", 32'h0000_02FC, osp);
    endtask : t_push_err
    task automatic t_pop_mem;
        logic [31:0] m;
        for (int i = 0; i < 2; i++) begin
            op32 = i[0];
            stk32 = 1'b0;
            base32 = 1'b1;
            m = i[0] ? 32'hFFFF_FFFF : 32'h0000_FFFF;
            sp = {16'h0007, i[0] ? WRAP_OP32 : WRAP_OP16};
            idx = 32'h0000_0040;
            u_mem.mem[sp] = 32'hCAFE_0001;
            u_mem.mem[idx] = 32'h0;
            run(OP_POP_MEM, -1);
            chk("wrapped pop dest", 32'hCAFE_0001 & m, u_mem.mem[idx] & m);
            chk("wrapped pop sp", 32'h0007_0000, osp);
        end
        base32 = 1'b0;
        u_mem.mem[32'h0000_0500] = 32'h0;
        run(OP_POP_MEM, -1);
        chk("plain pop dest", 32'hCAFE_0001, u_mem.mem[32'h0000_0500]);
        chk("plain pop sp", 32'h0007_0000, osp);
        stk32 = 1'b1;
    endtask : t_pop_mem
    task automatic t_far_call;
        op32 = 1'b1;
        sp = 32'h0000_0400;
        sel = 16'h0010;
        ip = 32'h1234_5678;
        u_mem.mem[32'h0000_03FC] = 32'hA5A5_A5A5;
        run(OP_FAR_CALL, -1);
        chk("call selector", 32'hA5A5_0010, u_mem.mem[32'h0000_03FC]);
        chk("call return", 32'h1234_5678, u_mem.mem[32'h0000_03F8]);
        for (int i = 0; i < 2; i++) begin
            lim = (i == 0);
            rts = (i == 1);
            wr0 = u_mem.wr_cnt;
            run(OP_FAR_CALL, -1);
            chk("branch fault code", {30'h0, FLT_BRANCH}, {30'h0, fc});
            chk("writes on branch fault", wr0, u_mem.wr_cnt);
        end
        lim = 1'b0;
        rts = 1'b0;
    endtask : t_far_call
    task automatic t_abort;
        sp = 32'h0000_0500;
        dly = 4'h6;
        u_mem.mem[32'h0000_04FC] = 32'hA5A5_A5A5;
        run(OP_PUSH_SEL, 2);
        chk("abort code", {30'h0, FLT_ABORT}, {30'h0, fc});
        chk("abort sp", 32'h0000_0500, osp);
        chk("abort slot", 32'hA5A5_A5A5, u_mem.mem[32'h0000_04FC]);
        dly = 4'h0;
    endtask : t_abort
    // ========
    // main sequence and watchdog
    initial begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        t_push_sel();
        t_pop_sel();
        t_push_err();
        t_pop_mem();
        t_far_call();
        t_abort();
        conclude();
    end
    initial begin
        #100000;
        bad_count++;
        conclude();
    end
endmodule : ssp_engine_tb
`default_nettype wire

// ---- tb/ssp_mem_model.sv ----
// behavioural stack memory answering one request at a time
// assumes requests held until ack; i_dly sets wait cycles
`timescale 1ns/1ps
`default_nettype none
module ssp_mem_model (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_req,
    input wire logic i_we,
    input wire logic [31:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_be,
    input wire logic [3:0] i_dly,
    output logic o_ack,
    output logic [31:0] o_rdata
);
    logic [31:0] mem [logic [31:0]];
    logic [31:0] t;
    logic [3:0] cnt;
    int wr_cnt = 0;
    // ========
    // answer logic; read data toggles when not valid
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ack <= 1'b0;
            cnt <= 4'h0;
            o_rdata <= 32'h0;
        end else begin
            o_ack <= 1'b0;
            o_rdata <= ~o_rdata;
            if (!i_req || o_ack) begin
                cnt <= 4'h0;
            end else if (cnt < i_dly) begin
                cnt <= cnt + 4'h1;
            end else begin
                o_ack <= 1'b1;
                t = mem.exists(i_addr) ? mem[i_addr] : ~i_addr;
                if (i_we) begin
                    for (int i = 0; i < 4; i++) if (i_be[i]) t[8*i+:8] = i_wdata[8*i+:8];
                    mem[i_addr] = t;
                    wr_cnt++;
                end else begin
                    o_rdata <= t;
                end
            end
        end
    end
endmodule : ssp_mem_model
`default_nettype wire
